//--- temp_conv_pkg.sv
package temp_conv_pkg;

  // ----------------------------------------------------------
  // Register command bytes
  // ----------------------------------------------------------
  localparam logic [7:0] ADDR_MAIN_CFG = 8'h03;
  localparam logic [7:0] ADDR_INTERVAL = 8'h04;
  localparam logic [7:0] ADDR_CHAN_EN = 8'h05;
  localparam logic [7:0] ADDR_ONE_SHOT = 8'h0F;
  localparam logic [7:0] ADDR_MODEL_SEL = 8'h30;
  localparam logic [7:0] ADDR_OFFSET_A = 8'h31;
  localparam logic [7:0] ADDR_OFFSET_B = 8'h32;

  // ----------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------
  localparam int SOFT_SLEEP_BIT = 6;
  localparam int REMOTE_A_MODEL_BIT = 1;
  localparam int REMOTE_B_MODEL_BIT = 2;
  localparam logic [7:0] MASK_MAIN_CFG = 8'h40;
  localparam logic [7:0] MASK_INTERVAL = 8'h03;
  localparam logic [7:0] MASK_CHAN_EN = 8'h07;
  localparam logic [7:0] MASK_MODEL_SEL = 8'h06;
  localparam logic [7:0] RST_MAIN_CFG = 8'h00;
  localparam logic [7:0] RST_INTERVAL = 8'h02;
  localparam logic [7:0] RST_CHAN_EN = 8'h1F;
  localparam logic [7:0] RST_MODEL_SEL = 8'h02;
  localparam logic [7:0] RST_OFFSET = 8'h00;

  // ----------------------------------------------------------
  // Channels and interval codes
  // ----------------------------------------------------------
  localparam logic [1:0] CHAN_LOCAL = 2'h0;
  localparam logic [1:0] CHAN_REMOTE_A = 2'h1;
  localparam logic [1:0] CHAN_REMOTE_B = 2'h2;
  localparam logic [1:0] RATE_CONTINUOUS = 2'h0;
  localparam logic [1:0] RATE_SHORT = 2'h1;
  localparam logic [1:0] RATE_MID = 2'h2;

  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_TICK_NS = 1000000;
  localparam int MS_TICK_CYCLES = (MS_TICK_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam logic [11:0] INTERVAL_SHORT_MS = 12'h16C;
  localparam logic [11:0] INTERVAL_MID_MS = 12'h3E8;
  localparam logic [11:0] INTERVAL_LONG_MS = 12'h9C4;

  // ----------------------------------------------------------
  // Temperature format: sign, 7 integer, 3 fraction bits
  // ----------------------------------------------------------
  localparam int TEMP_W = 11;
  localparam int OFFSET_SHIFT = 2;

endpackage

//--- temp_offset_add.sv
`timescale 1ns/1ps
module temp_offset_add #(
  parameter int TEMP_W = temp_conv_pkg::TEMP_W
) (
  input wire logic [TEMP_W-1:0] raw,
  input wire logic [7:0] offset,
  output logic [TEMP_W-1:0] sum
);
  // Offset LSB is 0.5 C, reading LSB 0.125 C
  localparam int SH = temp_conv_pkg::OFFSET_SHIFT;
  localparam logic [TEMP_W:0] MAX_POS = {2'b00, {(TEMP_W-1){1'b1}}};
  localparam logic [TEMP_W:0] MAX_NEG = {2'b11, {(TEMP_W-1){1'b0}}};

  wire logic [TEMP_W:0] raw_x;
  wire logic [TEMP_W:0] off_x;
  wire logic [TEMP_W:0] total;
  wire logic over_pos;
  wire logic over_neg;

  assign raw_x = {raw[TEMP_W-1], raw};
  assign off_x = {{(TEMP_W+1-8-SH){offset[7]}}, offset, {SH{1'b0}}};
  assign total = raw_x + off_x;
  // Clip rather than wrap, so a hot part never reads cold
  assign over_pos = (total[TEMP_W:TEMP_W-1] == 2'b01);
  assign over_neg = (total[TEMP_W:TEMP_W-1] == 2'b10);
  assign sum = over_pos ? MAX_POS[TEMP_W-1:0] :
    over_neg ? MAX_NEG[TEMP_W-1:0] : total[TEMP_W-1:0];
endmodule

//--- temp_conv_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Model select bits 2,1; reset 0x02
// - Offsets are 8-bit two's complement, reset zero
// - Offset spans +63.5 to -64 degrees
// - Report raw result plus channel offset
// - Config bit 6 selects standby; reset 0x00
// - One-shot in standby runs one sequence
// - Rate field picks interval; reset 0x02
// - Convert channels in turn, then pad
// - Skip channels whose enable is clear
// - Continuous shortens; fixed rates keep interval
// - Enable bits 2..0 remote b, a, local
// - Unassigned bits always read zero
// - One-shot write data is not kept
// - Busy flag set while converting
module temp_conv_ctrl #(
  parameter int TICK_CYCLES = temp_conv_pkg::MS_TICK_CYCLES,
  parameter int TEMP_W = temp_conv_pkg::TEMP_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic conv_start,
  output logic [1:0] conv_chan,
  input wire logic conv_done,
  input wire logic [TEMP_W-1:0] conv_raw,
  output logic [TEMP_W-1:0] local_temp,
  output logic [TEMP_W-1:0] remote_a_temp,
  output logic [TEMP_W-1:0] remote_b_temp,
  output logic remote_a_model_sel,
  output logic remote_b_model_sel,
  output logic busy,
  output logic soft_sleep
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_NEXT = 2'b01,
    ST_WAIT = 2'b10,
    ST_PAD = 2'b11
  } seq_state_t;

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  logic [7:0] cfg_reg;
  logic [7:0] rate_reg;
  logic [7:0] en_reg;
  logic [7:0] model_reg;
  logic [7:0] off_a_reg;
  logic [7:0] off_b_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic oneshot_reg;
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [1:0] chan_reg;
  logic [2:0] seq_en_reg;
  logic [1:0] seq_rate_reg;
  logic seq_single_reg;
  logic start_reg;
  logic [1:0] start_chan_reg;
  logic busy_reg;
  logic [31:0] tick_cnt_reg;
  logic [11:0] ms_cnt_reg;
  logic [TEMP_W-1:0] temp_reg [3];

  // ----------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------
  wire logic wr_cfg = reg_wr && reg_addr == temp_conv_pkg::ADDR_MAIN_CFG;
  wire logic wr_rate = reg_wr && reg_addr == temp_conv_pkg::ADDR_INTERVAL;
  wire logic wr_en = reg_wr && reg_addr == temp_conv_pkg::ADDR_CHAN_EN;
  wire logic wr_model = reg_wr && reg_addr == temp_conv_pkg::ADDR_MODEL_SEL;
  wire logic wr_off_a = reg_wr && reg_addr == temp_conv_pkg::ADDR_OFFSET_A;
  wire logic wr_off_b = reg_wr && reg_addr == temp_conv_pkg::ADDR_OFFSET_B;
  wire logic wr_shot = reg_wr && reg_addr == temp_conv_pkg::ADDR_ONE_SHOT;
  wire logic sleep_w = cfg_reg[temp_conv_pkg::SOFT_SLEEP_BIT];
  wire logic [7:0] rd_mux;
  // Reads of unmapped or write-only bytes give zero
  assign rd_mux =
    (reg_addr == temp_conv_pkg::ADDR_MAIN_CFG) ? cfg_reg :
    (reg_addr == temp_conv_pkg::ADDR_INTERVAL) ? rate_reg :
    (reg_addr == temp_conv_pkg::ADDR_CHAN_EN) ? en_reg :
    (reg_addr == temp_conv_pkg::ADDR_MODEL_SEL) ? model_reg :
    (reg_addr == temp_conv_pkg::ADDR_OFFSET_A) ? off_a_reg :
    (reg_addr == temp_conv_pkg::ADDR_OFFSET_B) ? off_b_reg : 8'h00;

  // ----------------------------------------------------------
  // Register file
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_reg <= temp_conv_pkg::RST_MAIN_CFG;
      // Interval code resets to 1 s
      rate_reg <= temp_conv_pkg::RST_INTERVAL & temp_conv_pkg::MASK_INTERVAL;
      en_reg <= temp_conv_pkg::RST_CHAN_EN & temp_conv_pkg::MASK_CHAN_EN;
      // Remote a compensated, remote b discrete
      model_reg <= temp_conv_pkg::RST_MODEL_SEL;
      off_a_reg <= temp_conv_pkg::RST_OFFSET;
      off_b_reg <= temp_conv_pkg::RST_OFFSET;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      // Masks drop writes to unassigned bits
      if (wr_cfg) cfg_reg <= reg_wdata & temp_conv_pkg::MASK_MAIN_CFG;
      if (wr_rate) rate_reg <= reg_wdata & temp_conv_pkg::MASK_INTERVAL;
      if (wr_en) en_reg <= reg_wdata & temp_conv_pkg::MASK_CHAN_EN;
      if (wr_model) model_reg <= reg_wdata & temp_conv_pkg::MASK_MODEL_SEL;
      // Full byte kept, so +63.5 down to -64 fits
      if (wr_off_a) off_a_reg <= reg_wdata;
      if (wr_off_b) off_b_reg <= reg_wdata;
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
      rvalid_reg <= reg_rd;
    end
  end

  // ----------------------------------------------------------
  // One-shot request
  // ----------------------------------------------------------
  wire logic shot_take = (state_reg == ST_IDLE) && oneshot_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      oneshot_reg <= 1'b0;
    end else if (wr_shot && sleep_w) begin
      // Any byte triggers; data is discarded
      oneshot_reg <= 1'b1;
    end else if (shot_take || !sleep_w) begin
      oneshot_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Millisecond divider and interval timer
  // ----------------------------------------------------------
  wire logic ms_tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
  wire logic seq_begin = (state_reg == ST_IDLE && (!sleep_w || oneshot_reg))
    || (state_reg == ST_PAD && state_next == ST_NEXT)
    || ((state_reg == ST_NEXT || state_reg == ST_WAIT)
        && state_next == ST_NEXT && chan_reg == 2'h2
        && seq_rate_reg == temp_conv_pkg::RATE_CONTINUOUS);
  wire logic [11:0] target_ms =
    (seq_rate_reg == temp_conv_pkg::RATE_SHORT) ?
      temp_conv_pkg::INTERVAL_SHORT_MS :
    (seq_rate_reg == temp_conv_pkg::RATE_MID) ?
      temp_conv_pkg::INTERVAL_MID_MS : temp_conv_pkg::INTERVAL_LONG_MS;
  wire logic interval_over = (ms_cnt_reg >= target_ms);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || seq_begin) begin
      tick_cnt_reg <= 32'h0000_0000;
      ms_cnt_reg <= 12'h000;
    end else if (ms_tick) begin
      tick_cnt_reg <= 32'h0000_0000;
      if (!interval_over) ms_cnt_reg <= ms_cnt_reg + 12'h001;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------
  wire logic last_chan = (chan_reg == 2'h2);
  wire logic chan_on = seq_en_reg[chan_reg];
  wire logic end_single = seq_single_reg || sleep_w;
  seq_state_t end_state;
  // Continuous restarts at once, skips shorten it
  assign end_state = end_single ? ST_IDLE :
    (seq_rate_reg == temp_conv_pkg::RATE_CONTINUOUS) ? ST_NEXT : ST_PAD;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // Standby waits for a one-shot request
        if (!sleep_w || oneshot_reg) state_next = ST_NEXT;
      end
      ST_NEXT: begin
        if (chan_on) state_next = ST_WAIT;
        else if (!last_chan) state_next = ST_NEXT;
        else state_next = end_state;
      end
      ST_WAIT: begin
        // Last channel done ends the sequence, no silent wrap
        if (conv_done && last_chan) state_next = end_state;
        else if (conv_done) state_next = ST_NEXT;
      end
      ST_PAD: begin
        // Standby drops to idle at once; otherwise fill out the rest of the interval
        if (sleep_w) state_next = ST_IDLE;
        else if (interval_over) state_next = ST_NEXT;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  wire logic chan_step = (state_reg == ST_NEXT && !chan_on)
    || (state_reg == ST_WAIT && conv_done);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      chan_reg <= temp_conv_pkg::CHAN_LOCAL;
      seq_en_reg <= 3'h0;
      seq_rate_reg <= temp_conv_pkg::RATE_CONTINUOUS;
      seq_single_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // Settings sampled only when a sequence begins
      if (seq_begin) begin
        chan_reg <= temp_conv_pkg::CHAN_LOCAL;
        seq_en_reg <= en_reg[2:0];
        seq_rate_reg <= rate_reg[1:0];
        seq_single_reg <= sleep_w;
      end else if (chan_step) begin
        chan_reg <= last_chan ? temp_conv_pkg::CHAN_LOCAL
          : chan_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------
  // Converter handshake and busy
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      start_reg <= 1'b0;
      start_chan_reg <= temp_conv_pkg::CHAN_LOCAL;
      busy_reg <= 1'b0;
    end else begin
      start_reg <= (state_reg == ST_NEXT) && chan_on;
      start_chan_reg <= chan_reg;
      // Busy spans launch to converter done
      busy_reg <= (state_next == ST_WAIT);
    end
  end

  // ----------------------------------------------------------
  // Offset correction, one adder per remote channel
  // ----------------------------------------------------------
  wire logic [7:0] offs [3];
  wire logic [TEMP_W-1:0] corrected [3];
  assign offs[0] = 8'h00;
  assign offs[1] = off_a_reg;
  assign offs[2] = off_b_reg;
  assign corrected[0] = conv_raw;

  genvar gi;
  generate
    for (gi = 1; gi < 3; gi++) begin : g_remote
      // Offset added before the value is reported
      temp_offset_add #(.TEMP_W(TEMP_W)) u_add (
        .raw(conv_raw),
        .offset(offs[gi]),
        .sum(corrected[gi])
      );
    end
    for (gi = 0; gi < 3; gi++) begin : g_store
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          temp_reg[gi] <= '0;
        end else if (state_reg == ST_WAIT && conv_done
            && chan_reg == 2'(gi)) begin
          temp_reg[gi] <= corrected[gi];
        end
      end
    end
  endgenerate

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign conv_start = start_reg;
  assign conv_chan = start_chan_reg;
  assign local_temp = temp_reg[0];
  assign remote_a_temp = temp_reg[1];
  assign remote_b_temp = temp_reg[2];
  assign remote_a_model_sel = model_reg[temp_conv_pkg::REMOTE_A_MODEL_BIT];
  assign remote_b_model_sel = model_reg[temp_conv_pkg::REMOTE_B_MODEL_BIT];
  assign busy = busy_reg;
  assign soft_sleep = sleep_w;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  model_reset_a: assert property (
    $past(!rst_n) |-> model_reg == 8'h02 && en_reg == 8'h07)
    else $error("Bad reset value in model or enable");
  offset_sum_a: assert property (
    state_reg == ST_WAIT && conv_done && chan_reg == 2'h1
    |=> remote_a_temp == $past(corrected[1]))
    else $error("Remote a value lacks offset");
  reserved_zero_a: assert property (
    reg_rd && reg_addr == temp_conv_pkg::ADDR_MAIN_CFG
    |=> reg_rvalid && (reg_rdata & 8'hBF) == 8'h00)
    else $error("Reserved config bit read nonzero");
  oneshot_idle_a: assert property (
    state_reg == ST_IDLE && sleep_w && !oneshot_reg
    |=> state_reg == ST_IDLE)
    else $error("Sequence left standby without request");
  shot_ignored_a: assert property (
    wr_shot && !sleep_w |=> !oneshot_reg)
    else $error("One-shot taken outside standby");
  busy_start_a: assert property (
    start_reg |-> busy_reg && seq_en_reg[start_chan_reg])
    else $error("Launch without busy or on disabled channel");
  pad_hold_a: assert property (
    state_reg == ST_PAD && !sleep_w && !interval_over
    |=> state_reg == ST_PAD)
    else $error("Padding ended before interval");
  skip_fast_a: assert property (
    state_reg == ST_NEXT && !chan_on |=> !start_reg)
    else $error("Disabled channel was converted");
endmodule

//--- conv_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// Converter stand-in: answers each launch after a set delay
// ----------------------------------------------------------
module conv_model #(
  parameter int W = temp_conv_pkg::TEMP_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic conv_start,
  input wire logic [1:0] conv_chan,
  input wire logic [3:0] delay,
  input wire logic [3*W-1:0] raw_set,
  output logic conv_done,
  output logic [W-1:0] conv_raw
);
  logic [3:0] cnt;
  logic [1:0] chan;
  logic run;
  // Result only valid in the done cycle; toggles otherwise
  always_ff @(posedge sys_clk) begin
    conv_done <= 1'b0;
    conv_raw <= ~conv_raw;
    if (!rst_n) begin
      run <= 1'b0;
      cnt <= 4'h0;
      chan <= 2'h0;
      conv_raw <= '0;
    end else if (conv_start) begin
      run <= 1'b1;
      cnt <= delay;
      chan <= conv_chan;
    end else if (run && cnt == 4'h0) begin
      run <= 1'b0;
      conv_done <= 1'b1;
      conv_raw <= raw_set[chan*W+:W];
    end else if (run) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule

//--- temp_conv_ctrl_test.sv
`timescale 1ns/1ps
module temp_conv_ctrl_test;
  localparam int TICK = 10;
  localparam int W = temp_conv_pkg::TEMP_W;
  localparam logic [7:0] ADR [8] = '{8'h03, 8'h04, 8'h05, 8'h30,
    8'h31, 8'h32, 8'h0F, 8'h77};
  localparam logic [7:0] RV [8] = '{8'h00, 8'h02, 8'h07, 8'h02,
    8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MV [8] = '{8'h40, 8'h03, 8'h07, 8'h06,
    8'hFF, 8'hFF, 8'h00, 8'h00};
  logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_rvalid, conv_start, conv_done, busy, soft_sleep;
  logic remote_a_model_sel, remote_b_model_sel;
  logic [1:0] conv_chan;
  logic [W-1:0] conv_raw, local_temp, remote_a_temp, remote_b_temp;
  logic [3*W-1:0] raw_set = '0;
  logic [3:0] delay = 4'h5;
  logic [1:0] q[$];
  int num_errors = 0, tests_run = 0, seed = 9852, cyc = 0;

  temp_conv_ctrl #(.TICK_CYCLES(TICK)) dut (.sys_clk, .rst_n, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .conv_start,
    .conv_chan, .conv_done, .conv_raw, .local_temp, .remote_a_temp,
    .remote_b_temp, .remote_a_model_sel, .remote_b_model_sel, .busy,
    .soft_sleep);
  conv_model m_conv (.sys_clk, .rst_n, .conv_start, .conv_chan, .delay,
    .raw_set, .conv_done, .conv_raw);

  initial forever #20 sys_clk = ~sys_clk;

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic check(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (conv_start === 1'b1) q.push_back(conv_chan);
    if (conv_done === 1'b1) check(busy === 1'b1, "busy low at done");
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    check(reg_rvalid === 1'b1 && reg_rdata === e, $sformatf("read %h", a));
  endtask

  // Bounded so a stalled sequencer ends the run instead of hanging
  task automatic wait_loc(output int t);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (!(conv_start === 1'b1 && conv_chan === 2'h0) && n < 30000);
    if (n >= 30000) begin
      check(1'b0, "no local start");
      stop_test;
    end
    t = cyc;
  endtask

  // Config written early in a sequence takes hold at the next one
  task automatic measure(input logic [7:0] a, input logic [7:0] d,
    output int p);
    int t0, t1;
    wr(a, d);
    wait_loc(t0);
    wait_loc(t1);
    p = t1 - t0;
  endtask

  function automatic bit in_win(int p, int ms);
    return p >= (ms - 1) * TICK && p <= ms * TICK + 4;
  endfunction

  function automatic logic [W-1:0] add_off(logic [W-1:0] r,
    logic [7:0] o);
    int s;
    s = int'($signed(r)) + 4 * int'($signed(o));
    if (s > 1023)
      s = 1023;
    if (s < -1024)
      s = -1024;
    return s[W-1:0];
  endfunction

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    int p, p1, n, t0, t1;
    logic [31:0] x;
    logic [7:0] oa, ob, en;
    logic [1:0] e[$];
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    wait_loc(t0);
    wait_loc(t1);
    check(in_win(t1 - t0, 1000), "reset rate");
    check(remote_a_model_sel === 1'b1 && remote_b_model_sel === 1'b0 &&
      soft_sleep === 1'b0, "reset ports");
    for (int i = 0; i < 8; i++) rd_chk(ADR[i], RV[i]);
    $display("test reset done");
    measure(8'h04, 8'h01, p);
    check(in_win(p, 364), "rate 01");
    measure(8'h05, 8'h01, p);
    check(in_win(p, 364), "padded rate");
    measure(8'h04, 8'h03, p);
    check(in_win(p, 2500), "rate 11");
    measure(8'h04, 8'h00, p1);
    measure(8'h05, 8'h07, p);
    check(p1 < p && p < 364 * TICK, "continuous");
    $display("test rates done");
    wr(8'h30, 8'h04);
    check(remote_a_model_sel === 1'b0 && remote_b_model_sel === 1'b1,
      "model ports");
    for (int i = 0; i < 8; i++) wr(ADR[i], 8'hFF);
    for (int i = 0; i < 8; i++) rd_chk(ADR[i], MV[i]);
    check(soft_sleep === 1'b1 && remote_a_model_sel === 1'b1,
      "sleep");
    repeat (100) @(negedge sys_clk);
    q.delete();
    repeat (100) @(negedge sys_clk);
    check(q.size() == 0, "standby still converting");
    $display("test masks done");
    for (int r = 0; r < 8; r++) begin
      x = $random(seed);
      oa = (r == 0) ? 8'h7F : x[7:0];
      ob = (r == 0) ? 8'h80 : x[15:8];
      en = (x[18:16] == 3'h0) ? 8'h06 : {5'h00, x[18:16]};
      if (r == 0)
        en = 8'h07;
      delay = x[22:19];
      raw_set = {$random(seed), x[31]};
      if (r == 0)
        raw_set = {11'h400, 11'h3FF, 11'h123};
      wr(8'h31, oa);
      wr(8'h32, ob);
      wr(8'h05, en);
      q.delete();
      e.delete();
      for (int c = 0; c < 3; c++) if (en[c]) e.push_back(2'(c));
      wr(8'h0F, x[7:0]);
      n = 0;
      while (!(q.size() == e.size() && busy === 1'b0) && n < 500) begin
        @(negedge sys_clk);
        n++;
      end
      @(negedge sys_clk);
      check(n < 500 && q == e, "one-shot order");
      if (en[0]) check(local_temp === raw_set[10:0], "local");
      if (en[1])
        check(remote_a_temp === add_off(raw_set[21:11], oa), "a");
      if (en[2])
        check(remote_b_temp === add_off(raw_set[32:22], ob), "b");
      repeat (60) @(negedge sys_clk);
      check(q.size() == e.size() && busy === 1'b0, "extra runs");
      rd_chk(8'h0F, 8'h00);
      rd_chk(8'h31, oa);
    end
    $display("test one-shot done");
    stop_test;
  end
endmodule
